// ==== testbench/ieg_host_model.sv ====
// Host model that polls the interrupt endpoint
`timescale 1ns/1ps
module ieg_host_model (
  // Clock
  input  wire logic        aclk,
  // Poll request from the bench
  input  wire logic        poll,
  // Interrupt endpoint
  output logic             interval_tick,
  input  wire logic        report_valid,
  input  wire logic [31:0] report_status,
  // Last packet seen
  output logic             got,
  output logic [31:0]      got_status
);
  // One tick per poll; a packet is captured whenever it appears
  always @(posedge aclk) begin
    interval_tick <= poll;
    if (poll) got <= 1'b0;
    if (report_valid) begin
      got <= 1'b1;
      got_status <= report_status;
    end
  end
endmodule : ieg_host_model

// ==== testbench/tb.sv ====
// Self-checking bench of the interrupt endpoint event gate
`timescale 1ns/1ps
module tb;
  import ieg_pkg::*;
  logic         aclk, aresetn, phy_n, poll, tick, rv, got;
  ieg_axi_req_t req;
  ieg_axi_rsp_t rsp;
  ieg_events_t  ev;
  logic [31:0]  rs, gs, rd;
  logic [1:0]   rr;
  int           err_total, cmp_count;
  ieg_gate dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .events_in(ev), .phy_irq_in_n(phy_n),
    .interval_tick(tick), .report_valid(rv), .report_status(rs));
  ieg_host_model host (.aclk(aclk), .poll(poll), .interval_tick(tick),
    .report_valid(rv), .report_status(rs), .got(got), .got_status(gs));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [31:0] a, logic [31:0] d);
    req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    rr = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd_reg(logic [31:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg
  task automatic fire(int i);
    if (i == 17) phy_n <= 1'b0;
    else ev <= ieg_events_t'(32'h1 << i);
    @(posedge aclk);
    ev <= '0;
    repeat (3) @(posedge aclk);
    phy_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : fire
  task automatic pl();
    poll <= 1'b1;
    @(posedge aclk);
    poll <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pl
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    wrap_up();
  end
  initial begin
    aresetn = 1'b0;
    req = '0;
    ev = '0;
    phy_n = 1'b1;
    poll = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_reg(32'h98);
    chk("enable reset", 32'h0, rd);
    wr(32'h98, 32'hffff_ffff);
    chk("write resp", 32'h0, {30'h0, rr});
    rd_reg(32'h98);
    chk("enable readback", 32'h97ff_ffff, rd);
    rd_reg(32'hf0);
    chk("unmapped resp", 32'h3, {30'h0, rr});
    $display("Test registers done");
    // Each source alone, then all but it
    for (int i = 0; i < 29; i++) begin
      if (i == 27) continue;
      wr(32'h98, 32'h1 << i);
      fire(i);
      rd_reg(32'ha0);
      chk("pending latched", 32'h1 << i, rd);
      pl();
      chk("packet sent", 32'h1, {31'h0, got});
      chk("packet status", 32'h1 << i, gs);
      wr(32'h98, 32'h17ff_ffff & ~(32'h1 << i));
      fire(i);
      pl();
      chk("packet held back", 32'h0, {31'h0, got});
    end
    $display("Test event gating done");
    wr(32'h98, 32'h8000_0000);
    pl();
    chk("always on sent", 32'h1, {31'h0, got});
    chk("always on status", 32'h0, gs);
    pl();
    chk("always on again", 32'h1, {31'h0, got});
    $display("Test always on done");
    wrap_up();
  end
endmodule : tb

// ==== verilog/ieg_gate.sv ====
// Interrupt endpoint event gate with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ieg_map.svh"

// Summary of operation
// - Always-on bit: report every polling interval
// - Otherwise report only after enabled event
// - OTP write done reported only when bit 28
// - TX low-power entry gated by bit 26
// - TX low-power exit gated by bit 25
// - RX low-power event gated by bit 24
// - MAC reset timeout gated by bit 23
// - RX FIFO overflow gated by bit 22
// - Transmit error gated by bit 21
// - USB status event gated by bit 20
// - TX stopped event gated by bit 19
// - RX stopped event gated by bit 18
// - PHY interrupt pin gated by bit 17
// - Data port event gated by bit 16
// - MAC fault event gated by bit 15
// - TX FIFO underrun gated by bit 14
// - TX FIFO overrun gated by bit 13
// - Bulk-in frame pending gated by bit 12
// - Twelve pin events gated by bits 11:0
module ieg_gate (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Register bus
  input  wire ieg_pkg::ieg_axi_req_t axi_req,
  output wire ieg_pkg::ieg_axi_rsp_t axi_rsp,
  // Event sources
  input  wire ieg_pkg::ieg_events_t  events_in,
  input  wire logic              phy_irq_in_n,
  // Interrupt endpoint
  input  wire logic              interval_tick,
  output wire logic              report_valid,
  output wire logic [31:0]       report_status
);
  import ieg_pkg::*;

  ieg_state_t  st_r;
  ieg_state_t  st_nxt;
  logic [31:0] ev;
  logic [31:0] hit;

  always_comb begin
    st_nxt = st_r;
    ev     = 32'h0000_0000;
    // PHY pin is asynchronous: two flops before use
    st_nxt.phy_s1 = ~phy_irq_in_n;
    st_nxt.phy_s2 = st_r.phy_s1;
    ev = events_in;
    ev[`IEG_BIT_PHY] = st_r.phy_s2;
    ev = ev & `IEG_EVENT_MASK;
    // Address and data channels taken in either order
    if (st_r.aw_rdy && axi_req.awvalid) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_a    = axi_req.awaddr[11:0];
    end
    if (st_r.w_rdy && axi_req.wvalid) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_d    = axi_req.wdata;
      st_nxt.w_s    = axi_req.wstrb;
    end
    if (st_r.aw_full && st_r.w_full && !st_r.b_v) begin
      st_nxt.b_v     = 1'b1;
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.b_r     = `IEG_RESP_OKAY;
      if (st_r.aw_a == `IEG_ENABLE_OFS) begin
        for (int i = 0; i < 4; i++) begin
          if (st_r.w_s[i]) begin
            st_nxt.en[8*i +: 8] = st_r.w_d[8*i +: 8];
          end
        end
        st_nxt.en = st_nxt.en & `IEG_WMASK;
      end else if (st_r.aw_a != `IEG_PENDING_OFS) begin
        st_nxt.b_r = `IEG_RESP_DECERR;
      end
    end
    if (st_r.b_v && axi_req.bready) begin
      st_nxt.b_v = 1'b0;
    end
    // Read channel
    if (st_r.ar_rdy && axi_req.arvalid) begin
      st_nxt.r_v = 1'b1;
      st_nxt.r_r = `IEG_RESP_OKAY;
      if (axi_req.araddr[11:0] == `IEG_ENABLE_OFS) begin
        st_nxt.r_d = st_r.en;
      end else if (axi_req.araddr[11:0] == `IEG_PENDING_OFS) begin
        st_nxt.r_d = st_r.pend;
      end else begin
        st_nxt.r_d = 32'h0000_0000;
        st_nxt.r_r = `IEG_RESP_DECERR;
      end
    end else if (st_r.r_v && axi_req.rready) begin
      st_nxt.r_v = 1'b0;
    end
    st_nxt.aw_rdy = !st_nxt.aw_full && !st_nxt.b_v;
    st_nxt.w_rdy  = !st_nxt.w_full && !st_nxt.b_v;
    st_nxt.ar_rdy = !st_nxt.r_v;
    // Gate and latch events; a new event beats the report clear
    hit = ev &
          st_r.en;
    st_nxt.pend = ((interval_tick ? 32'h0000_0000 : st_r.pend) &
                   st_r.en) | hit;
    // Report at the polling interval
    st_nxt.rep_v = interval_tick && (st_r.en[`IEG_BIT_ALWAYS_ON] ||
                   (|st_r.pend));
    if (interval_tick) begin
      st_nxt.rep_d = st_r.pend;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r    <= '0;
      st_r.en <= `IEG_ENABLE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp.awready = st_r.aw_rdy;
  assign axi_rsp.wready  = st_r.w_rdy;
  assign axi_rsp.bvalid  = st_r.b_v;
  assign axi_rsp.bresp   = st_r.b_r;
  assign axi_rsp.arready = st_r.ar_rdy;
  assign axi_rsp.rvalid  = st_r.r_v;
  assign axi_rsp.rdata   = st_r.r_d;
  assign axi_rsp.rresp   = st_r.r_r;
  assign report_valid    = st_r.rep_v;
  assign report_status   = st_r.rep_d;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_always_on;
    interval_tick && st_r.en[`IEG_BIT_ALWAYS_ON] |=> report_valid;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on report missing");

  property p_quiet;
    interval_tick && !st_r.en[`IEG_BIT_ALWAYS_ON] && st_r.pend == '0
      |=> !report_valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("report sent with nothing pending");

  property p_report_pending;
    interval_tick && st_r.pend != '0 |=>
      report_valid && report_status == $past(st_r.pend);
  endproperty
  a_report_pending: assert property (p_report_pending)
    else $error("pending events not reported");

  property p_otp;
    events_in.otp_write_done && st_r.en[`IEG_BIT_OTP]
      |=> st_r.pend[`IEG_BIT_OTP];
  endproperty
  a_otp: assert property (p_otp)
    else $error("otp event not latched");

  property p_mac_rto;
    events_in.mac_reset_timeout && st_r.en[`IEG_BIT_MAC_RTO]
      |=> st_r.pend[`IEG_BIT_MAC_RTO];
  endproperty
  a_mac_rto: assert property (p_mac_rto)
    else $error("mac reset timeout not latched");

  property p_phy;
    (!phy_irq_in_n && st_r.en[`IEG_BIT_PHY]) [*3] |=>
      st_r.pend[`IEG_BIT_PHY];
  endproperty
  a_phy: assert property (p_phy)
    else $error("phy pin event not latched");

  property p_gated_off;
    (st_r.pend & ~$past(st_r.en)) == 32'h0000_0000;
  endproperty
  a_gated_off: assert property (p_gated_off)
    else $error("disabled event latched");

  property p_hold_until_report;
    st_r.pend[0] && !interval_tick && st_r.en[0] |=> st_r.pend[0];
  endproperty
  a_hold_until_report: assert property (p_hold_until_report)
    else $error("pending event dropped before report");

  property p_reserved;
    (st_r.en & ~`IEG_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved enable bit set");

  property p_tx_entry;
    events_in.tx_low_power_entry && st_r.en[`IEG_BIT_TX_ENTRY]
      |=> st_r.pend[`IEG_BIT_TX_ENTRY];
  endproperty
  a_tx_entry: assert property (p_tx_entry)
    else $error("tx low-power entry not latched");

  property p_tx_exit;
    events_in.tx_low_power_exit && st_r.en[`IEG_BIT_TX_EXIT]
      |=> st_r.pend[`IEG_BIT_TX_EXIT];
  endproperty
  a_tx_exit: assert property (p_tx_exit)
    else $error("tx low-power exit not latched");

  property p_rx_lpi;
    events_in.rx_low_power && st_r.en[`IEG_BIT_RX_LPI]
      |=> st_r.pend[`IEG_BIT_RX_LPI];
  endproperty
  a_rx_lpi: assert property (p_rx_lpi)
    else $error("rx low-power event not latched");

  property p_rx_ovf;
    events_in.rx_fifo_overflow && st_r.en[`IEG_BIT_RX_OVF]
      |=> st_r.pend[`IEG_BIT_RX_OVF];
  endproperty
  a_rx_ovf: assert property (p_rx_ovf)
    else $error("rx fifo overflow not latched");

  property p_tx_err;
    events_in.tx_error && st_r.en[`IEG_BIT_TX_ERR]
      |=> st_r.pend[`IEG_BIT_TX_ERR];
  endproperty
  a_tx_err: assert property (p_tx_err)
    else $error("transmit error not latched");

  property p_usb_sts;
    events_in.usb_status_event && st_r.en[`IEG_BIT_USB_STS]
      |=> st_r.pend[`IEG_BIT_USB_STS];
  endproperty
  a_usb_sts: assert property (p_usb_sts)
    else $error("usb status event not latched");

  property p_tx_stop;
    events_in.tx_stopped && st_r.en[`IEG_BIT_TX_STOP]
      |=> st_r.pend[`IEG_BIT_TX_STOP];
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("tx stopped event not latched");

  property p_rx_stop;
    events_in.rx_stopped && st_r.en[`IEG_BIT_RX_STOP]
      |=> st_r.pend[`IEG_BIT_RX_STOP];
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("rx stopped event not latched");

  property p_dport;
    events_in.data_port_event && st_r.en[`IEG_BIT_DPORT]
      |=> st_r.pend[`IEG_BIT_DPORT];
  endproperty
  a_dport: assert property (p_dport)
    else $error("data port event not latched");

  property p_mac_err;
    events_in.mac_fault && st_r.en[`IEG_BIT_MAC_ERR]
      |=> st_r.pend[`IEG_BIT_MAC_ERR];
  endproperty
  a_mac_err: assert property (p_mac_err)
    else $error("mac fault event not latched");

  property p_tx_under;
    events_in.tx_fifo_underrun && st_r.en[`IEG_BIT_TX_UNDER]
      |=> st_r.pend[`IEG_BIT_TX_UNDER];
  endproperty
  a_tx_under: assert property (p_tx_under)
    else $error("tx fifo underrun not latched");

  property p_tx_over;
    events_in.tx_fifo_overrun && st_r.en[`IEG_BIT_TX_OVER]
      |=> st_r.pend[`IEG_BIT_TX_OVER];
  endproperty
  a_tx_over: assert property (p_tx_over)
    else $error("tx fifo overrun not latched");

  property p_bulk_fp;
    events_in.bulk_in_frame_pending && st_r.en[`IEG_BIT_BULK_FP]
      |=> st_r.pend[`IEG_BIT_BULK_FP];
  endproperty
  a_bulk_fp: assert property (p_bulk_fp)
    else $error("bulk-in frame pending not latched");

  property p_otp_off;
    events_in.otp_write_done && !st_r.en[`IEG_BIT_OTP]
      |=> !st_r.pend[`IEG_BIT_OTP];
  endproperty
  a_otp_off: assert property (p_otp_off)
    else $error("disabled otp event latched");

  property p_phy_off;
    st_r.phy_s2 && !st_r.en[`IEG_BIT_PHY]
      |=> !st_r.pend[`IEG_BIT_PHY];
  endproperty
  a_phy_off: assert property (p_phy_off)
    else $error("disabled phy event latched");

  for (genvar g = 0; g < 12; g++) begin : g_pin
    property p_pin;
      @(posedge aclk) disable iff (!aresetn)
        events_in.pin_events[g] && st_r.en[g] |=> st_r.pend[g];
    endproperty
    a_pin: assert property (p_pin)
      else $error("pin event not latched");
  end

  property p_tick_clears;
    interval_tick && events_in == '0 && !st_r.phy_s2
      |=> st_r.pend == 32'h0000_0000;
  endproperty
  a_tick_clears: assert property (p_tick_clears)
    else $error("reported events not cleared");

  property p_report_at_tick;
    !interval_tick |=> !report_valid;
  endproperty
  a_report_at_tick: assert property (p_report_at_tick)
    else $error("report outside polling interval");

  property p_status_hold;
    !interval_tick |=> $stable(report_status);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("report status changed between ticks");

  property p_write_answer;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
      axi_rsp.wready |=> ##1 axi_rsp.bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");

  property p_ready_busy;
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
  endproperty
  a_ready_busy: assert property (p_ready_busy)
    else $error("write ready while response pending");

  property p_read_answer;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");

  property p_reserved_read;
    axi_req.arvalid && axi_rsp.arready &&
      axi_req.araddr[11:0] == `IEG_ENABLE_OFS
      |=> axi_rsp.rdata[30:29] == 2'b00 && !axi_rsp.rdata[27];
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved bit read as one");

  property p_unmapped_read;
    axi_req.arvalid && axi_rsp.arready &&
      axi_req.araddr[11:0] != `IEG_ENABLE_OFS &&
      axi_req.araddr[11:0] != `IEG_PENDING_OFS
      |=> axi_rsp.rresp == `IEG_RESP_DECERR && axi_rsp.rdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not refused");

  c_always_on: cover property (interval_tick &&
    st_r.en[`IEG_BIT_ALWAYS_ON] ##1 report_valid);
  c_event_report: cover property (events_in.tx_error ##[1:20]
    report_valid && report_status[`IEG_BIT_TX_ERR]);
  c_write_read: cover property (axi_rsp.bvalid ##[1:10] axi_rsp.rvalid);
  c_phy_report: cover property (!phy_irq_in_n ##[1:20]
    report_valid && report_status[`IEG_BIT_PHY]);
  c_decerr: cover property (axi_rsp.rvalid &&
    axi_rsp.rresp == `IEG_RESP_DECERR);

endmodule : ieg_gate

// ==== verilog/ieg_map.svh ====
// Register offsets, field positions and reset values of the event gate
`ifndef IEG_MAP_SVH
`define IEG_MAP_SVH
`define IEG_ENABLE_OFS    12'h098
`define IEG_PENDING_OFS   12'h0a0
`define IEG_ENABLE_RST    32'h0000_0000
`define IEG_WMASK         32'h97ff_ffff
`define IEG_EVENT_MASK    32'h17ff_ffff
`define IEG_BIT_ALWAYS_ON 31
`define IEG_BIT_OTP       28
`define IEG_BIT_TX_ENTRY  26
`define IEG_BIT_TX_EXIT   25
`define IEG_BIT_RX_LPI    24
`define IEG_BIT_MAC_RTO   23
`define IEG_BIT_RX_OVF    22
`define IEG_BIT_TX_ERR    21
`define IEG_BIT_USB_STS   20
`define IEG_BIT_TX_STOP   19
`define IEG_BIT_RX_STOP   18
`define IEG_BIT_PHY       17
`define IEG_BIT_DPORT     16
`define IEG_BIT_MAC_ERR   15
`define IEG_BIT_TX_UNDER  14
`define IEG_BIT_TX_OVER   13
`define IEG_BIT_BULK_FP   12
`define IEG_RESP_OKAY     2'b00
`define IEG_RESP_DECERR   2'b11
`endif

// ==== verilog/ieg_pkg.sv ====
// Types of the interrupt endpoint event gate
package ieg_pkg;

  // Event pulses at their enable bit positions; reserved places, bit 17 (PHY pin) and bit 31 (always-on) unused
  typedef struct packed {
    logic [2:0]  spare_hi;
    logic        otp_write_done;
    logic        spare_27;
    logic        tx_low_power_entry;
    logic        tx_low_power_exit;
    logic        rx_low_power;
    logic        mac_reset_timeout;
    logic        rx_fifo_overflow;
    logic        tx_error;
    logic        usb_status_event;
    logic        tx_stopped;
    logic        rx_stopped;
    logic        spare_17;
    logic        data_port_event;
    logic        mac_fault;
    logic        tx_fifo_underrun;
    logic        tx_fifo_overrun;
    logic        bulk_in_frame_pending;
    logic [11:0] pin_events;
  } ieg_events_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } ieg_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ieg_axi_rsp_t;

  typedef struct packed {
    logic [31:0] en;
    logic [31:0] pend;
    logic        rep_v;
    logic [31:0] rep_d;
    logic        phy_s1;
    logic        phy_s2;
    logic        aw_rdy;
    logic        aw_full;
    logic [11:0] aw_a;
    logic        w_rdy;
    logic        w_full;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        b_v;
    logic [1:0]  b_r;
    logic        ar_rdy;
    logic        r_v;
    logic [31:0] r_d;
    logic [1:0]  r_r;
  } ieg_state_t;

endpackage : ieg_pkg
